// ===== rtl/aaxu_defs.svh
// Named constants for the absolute-value and add execution datapath.
// Assumes inclusion by the design files that use its constants; holds definitions only.
`ifndef AAXU_DEFS_SVH
`define AAXU_DEFS_SVH

// Logical unit opfields (7 bits).
`define AAXU_L_ABS32      7'h1A
`define AAXU_L_ABS40      7'h38
`define AAXU_L_ADD_32_32  7'h03
`define AAXU_L_ADD_32_40W 7'h23
`define AAXU_L_ADD_32L_40 7'h21
`define AAXU_L_ADD_C5_32  7'h02
`define AAXU_L_ADD_C5_40  7'h20
// Shift unit opfields (6 bits).
`define AAXU_S_ADD_REG    6'h07
`define AAXU_S_ADD_C5     6'h06
`define AAXU_S_ABS_SP     6'h3C
`define AAXU_S_ABS_DP     6'h2C
// Data address unit opfields (6 bits).
`define AAXU_D_ADD_REG    6'h10
`define AAXU_D_ADD_U5     6'h12

// Integer extreme values.
`define AAXU_MIN32        32'h8000_0000
`define AAXU_MAX32        32'h7FFF_FFFF
`define AAXU_MIN40        40'h80_0000_0000
`define AAXU_MAX40        40'h7F_FFFF_FFFF
// Floating-point special encodings.
`define AAXU_SP_NAN       32'h7FFF_FFFF
`define AAXU_SP_INF       32'h7F80_0000
`define AAXU_SP_EXP_ONES  8'hFF
`define AAXU_SP_QBIT      22
`define AAXU_DP_NAN_HI    32'h7FFF_FFFF
`define AAXU_DP_NAN_LO    32'hFFFF_FFFF
`define AAXU_DP_INF_HI    32'h7FF0_0000
`define AAXU_DP_EXP_ONES  11'h7FF
`define AAXU_DP_QBIT      19
`define AAXU_ZERO32       32'h0000_0000

`endif

// ===== rtl/aaxu_pkg.sv
// Types shared by the execution datapath files.
// Assumes the constants header is available to the design files.
package aaxu_pkg;
  // Functional unit that the decoder selected.
  typedef enum logic [1:0] {
    AAXU_UNIT_L = 2'b00,
    AAXU_UNIT_S = 2'b01,
    AAXU_UNIT_D = 2'b10,
    AAXU_UNIT_NONE = 2'b11
  } aaxu_unit_e;

  // Operation class chosen by decode.
  typedef enum logic [2:0] {
    AAXU_OP_NOP   = 3'b000,
    AAXU_OP_ABS32 = 3'b001,
    AAXU_OP_ABS40 = 3'b010,
    AAXU_OP_ADD   = 3'b011,
    AAXU_OP_MAGNITUDE_SP_OP = 3'b100,
    AAXU_OP_MAGNITUDE_DP_OP = 3'b101
  } aaxu_op_e;

  // Floating-point status flags.
  typedef struct packed {
    logic illegalOperand;
    logic secondSrcNotNumber;
    logic roundingLoss;
    logic secondSrcSubnormal;
    logic infiniteOut;
  } aaxu_flags_s;
endpackage : aaxu_pkg

// ===== rtl/aaxu_fp_if.sv
// Interface carrying a floating-point magnitude request and its answer.
// Assumes one clock domain; the top drives the request side.
`timescale 1ns/100ps
interface aaxu_fp_if;
  logic                 isDouble;  // High for double precision.
  logic [31:0]          srcHi;     // Upper word (or the single word).
  logic [31:0]          srcLo;     // Lower word of a double.
  logic [31:0]          resHi;     // Upper result word.
  logic [31:0]          resLo;     // Lower result word.
  aaxu_pkg::aaxu_flags_s flags;    // Status for this operand.

  modport requester (output isDouble, output srcHi, output srcLo,
                     input resHi, input resLo, input flags);
  modport responder (input isDouble, input srcHi, input srcLo,
                     output resHi, output resLo, output flags);
endinterface : aaxu_fp_if

// ===== rtl/aaxu_fp_mag.sv
// Combinational floating-point magnitude with special-case handling.
// Assumes the caller applies predicate and pipeline timing.
`timescale 1ns/100ps
`include "aaxu_defs.svh"
module aaxu_fp_mag (
  // Request and answer.
  aaxu_fp_if.responder fp
);
  // Field extraction for either precision.
  wire        spExpOnes = fp.srcHi[30:23] == `AAXU_SP_EXP_ONES;
  wire        spExpZero = fp.srcHi[30:23] == 8'h00;
  wire        spFracNz  = |fp.srcHi[22:0];
  wire        dpExpOnes = fp.srcHi[30:20] == `AAXU_DP_EXP_ONES;
  wire        dpExpZero = fp.srcHi[30:20] == 11'h000;
  wire        dpFracNz  = (|fp.srcHi[19:0]) | (|fp.srcLo);
  wire        expOnes   = fp.isDouble ? dpExpOnes : spExpOnes;
  wire        expZero   = fp.isDouble ? dpExpZero : spExpZero;
  wire        fracNz    = fp.isDouble ? dpFracNz : spFracNz;
  wire        quietBit  = fp.isDouble ? fp.srcHi[`AAXU_DP_QBIT]
                                      : fp.srcHi[`AAXU_SP_QBIT];
  // Classification of the operand.
  wire        isNan     = expOnes & fracNz;
  wire        isSnan    = isNan & ~quietBit;
  wire        isInf     = expOnes & ~fracNz;
  wire        isDenorm  = expZero & fracNz;
  wire [31:0] nanHi     = fp.isDouble ? `AAXU_DP_NAN_HI : `AAXU_SP_NAN;
  wire [31:0] infHi     = fp.isDouble ? `AAXU_DP_INF_HI : `AAXU_SP_INF;
  wire [31:0] nanLo     = fp.isDouble ? `AAXU_DP_NAN_LO : `AAXU_ZERO32;

  // Clearing the sign bit is the whole magnitude for ordinary numbers.
  assign fp.resHi = isNan ? nanHi :
                    isInf ? infHi :
                    isDenorm ? `AAXU_ZERO32 :
                    {1'b0, fp.srcHi[30:0]};
  assign fp.resLo = isNan ? nanLo :
                    (isDenorm | ~fp.isDouble) ? `AAXU_ZERO32 : fp.srcLo;
  // One driver for the whole flag word, in struct order, MSB first.
  assign fp.flags = {isSnan,
                     isNan,
                     isDenorm,
                     isDenorm,
                     isInf};
endmodule : aaxu_fp_mag

// ===== rtl/aaxu_int_sat.sv
// Combinational saturating integer magnitude for 32 and 40 bit operands.
// Assumes the caller picks the width by decode.
`timescale 1ns/100ps
`include "aaxu_defs.svh"
module aaxu_int_sat (
  // Operand and width select.
  input  wire logic        wide,
  input  wire logic [39:0] src,
  // Result.
  output logic      [39:0] res
);
  wire [31:0] s32   = src[31:0];
  wire [31:0] neg32 = 32'h0 - s32;
  wire [39:0] neg40 = 40'h0 - src;
  // Negation of the most negative value would wrap, so saturate instead.
  wire [31:0] abs32 = (s32 == `AAXU_MIN32) ? `AAXU_MAX32 :
                      s32[31] ? neg32 : s32;
  wire [39:0] abs40 = (src == `AAXU_MIN40) ? `AAXU_MAX40 :
                      src[39] ? neg40 : src;
  assign res = wide ? abs40 : {{8{abs32[31]}}, abs32};
endmodule : aaxu_int_sat

// ===== rtl/aaxu_exec.sv
// Execution datapath for integer and floating magnitude and integer add.
// Assumes decode supplies opfields and both register-file reads in E1.
//
// Summary of operation
// - Cross bit selects opposite-side operand.
// - 32-bit magnitude saturates most negative value.
// - 40-bit magnitude saturates most negative value.
// - Signalling NaN gives canonical NaN, two flags.
// - Quiet NaN gives canonical NaN, one flag.
// - Denormal gives plus zero, two flags.
// - Either infinity gives plus infinity, flag.
// - Double: low word E1, high E2.
// - Logical and shift units add sources.
// - Logical unit adds constant to 40-bit.
// - Signed constants sign-extend before adding.
// - Address and shift unit add forms.
`timescale 1ns/100ps
`include "aaxu_defs.svh"
module aaxu_exec (
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Decoded instruction in E1.
  input  wire logic                  issueValid,
  input  wire aaxu_pkg::aaxu_unit_e  unitSel,
  input  wire logic [6:0]            opfield,
  input  wire logic                  crossPath,
  input  wire logic                  predTrue,
  input  wire logic [4:0]            constField,
  // Operands from the destination side and the opposite side.
  input  wire logic [39:0]           src1Local,
  input  wire logic [39:0]           src2Local,
  input  wire logic [31:0]           src2Cross,
  input  wire logic [31:0]           src2HiLocal,
  input  wire logic [31:0]           src1Cross,
  // Results.
  output logic                       e1WriteEn,
  output logic [39:0]                e1Result,
  output logic                       e1IsLong,
  output logic                       e2WriteEn,
  output logic [31:0]                e2Result,
  output aaxu_pkg::aaxu_flags_s      fpFlags,
  output logic                       fpFlagsValid
);
  ////////////////////////////////////////////////////////////////////////
  // Decode.
  // Only active when a valid issue has a true predicate.
  wire go = issueValid & predTrue;
  wire isL = unitSel == aaxu_pkg::AAXU_UNIT_L;
  wire isS = unitSel == aaxu_pkg::AAXU_UNIT_S;
  wire isD = unitSel == aaxu_pkg::AAXU_UNIT_D;
  wire [5:0] op6 = opfield[5:0];
  wire lAbs32 = isL & (opfield == `AAXU_L_ABS32);
  wire lAbs40 = isL & (opfield == `AAXU_L_ABS40);
  wire lAdd3232 = isL & (opfield == `AAXU_L_ADD_32_32);
  wire lAdd32w = isL & (opfield == `AAXU_L_ADD_32_40W);
  wire lAdd3240 = isL & (opfield == `AAXU_L_ADD_32L_40);
  wire lAddC32 = isL & (opfield == `AAXU_L_ADD_C5_32);
  wire lAddC40 = isL & (opfield == `AAXU_L_ADD_C5_40);
  wire sAddReg = isS & (op6 == `AAXU_S_ADD_REG);
  wire sAddC = isS & (op6 == `AAXU_S_ADD_C5);
  wire sAbsSp = isS & (op6 == `AAXU_S_ABS_SP);
  wire sAbsDp = isS & (op6 == `AAXU_S_ABS_DP);
  wire dAddReg = isD & (op6 == `AAXU_D_ADD_REG);
  wire dAddU = isD & (op6 == `AAXU_D_ADD_U5);

  ////////////////////////////////////////////////////////////////////////
  // Operand selection.
  // The cross bit replaces the marked operand with the opposite file.
  wire [31:0] x2 = crossPath ? src2Cross : src2Local[31:0];
  wire [31:0] x1 = crossPath ? src1Cross : src1Local[31:0];
  wire [39:0] sc5 = {{35{constField[4]}}, constField};
  wire [39:0] uc5 = {35'h0, constField};
  wire [39:0] x2s = {{8{x2[31]}}, x2};
  wire [39:0] x1s = {{8{x1[31]}}, x1};
  wire [39:0] l1s = {{8{src1Local[31]}}, src1Local[31:0]};
  wire [39:0] l2s = {{8{src2Local[31]}}, src2Local[31:0]};

  // Addend pairs for each form; signed operands are two's complement.
  wire [39:0] addA = lAdd3240 ? x1s :
                     (lAddC32 | lAddC40 | sAddC) ? sc5 :
                     (dAddReg | dAddU) ? l2s : l1s;
  wire [39:0] addB = (lAdd3240 | lAddC40) ? src2Local :
                     dAddReg ? l1s :
                     dAddU ? uc5 : x2s;
  wire [39:0] addSum = addA + addB;
  wire addLong = lAdd32w | lAdd3240 | lAddC40;
  wire isAdd = lAdd3232 | lAdd32w | lAdd3240 | lAddC32 | lAddC40 |
               sAddReg | sAddC | dAddReg | dAddU;

  ////////////////////////////////////////////////////////////////////////
  // Integer magnitude.
  wire [39:0] absRes;
  aaxu_int_sat u_aaxu_int_sat (
    .wide (lAbs40),
    .src  (lAbs40 ? src2Local : {8'h00, x2}),
    .res  (absRes)
  );

  ////////////////////////////////////////////////////////////////////////
  // Floating magnitude; the double reads both halves in E1.
  aaxu_fp_if fpBus ();
  assign fpBus.isDouble = sAbsDp;
  assign fpBus.srcHi = sAbsDp ? src2HiLocal : x2;
  assign fpBus.srcLo = src2Local[31:0];
  aaxu_fp_mag u_aaxu_fp_mag (
    .fp (fpBus)
  );

  ////////////////////////////////////////////////////////////////////////
  // E1 result selection.
  wire intDone = go & (isAdd | lAbs32 | lAbs40);
  wire fpDone = go & (sAbsSp | sAbsDp);
  wire [39:0] e1Next = (lAbs32 | lAbs40) ? absRes :
                       isAdd ? (addLong ? addSum
                                        : {8'h00, addSum[31:0]}) :
                       {8'h00, fpBus.resLo};
  wire [39:0] e1Data = sAbsSp ? {8'h00, fpBus.resHi} : e1Next;

  // Integer results and the low double word are written in E1.
  always_comb begin
    e1WriteEn = intDone | fpDone;
    e1Result = e1Data;
    e1IsLong = (lAbs40 | addLong) & intDone;
  end

  // The upper double word is held for the E2 write.
  logic        e2Pend_q;    // Upper word due next cycle.
  logic [31:0] e2Word_q;    // Upper result word.
  logic        e2Pend_d;
  assign e2Pend_d = go & sAbsDp;

  // Register the E2 half; one delay slot.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      e2Pend_q <= 1'b0;
      e2Word_q <= `AAXU_ZERO32;
    end else begin
      e2Pend_q <= e2Pend_d;
      e2Word_q <= fpBus.resHi;
    end
  end
  assign e2WriteEn = e2Pend_q;
  assign e2Result = e2Word_q;

  // Flags come with the E1 write; a squashed op raises none.
  assign fpFlagsValid = fpDone;
  assign fpFlags = fpDone ? fpBus.flags : '0;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_nopred;
    @(posedge ref_clk) disable iff (rst)
      !(issueValid & predTrue) |-> !e1WriteEn && !fpFlagsValid;
  endproperty
  a_nopred: assert property (p_nopred)
    else $error("write on false pred");

  property p_dp_e2;
    @(posedge ref_clk) disable iff (rst)
      (go & sAbsDp) |-> e1WriteEn ##1 e2WriteEn;
  endproperty
  a_dp_e2: assert property (p_dp_e2)
    else $error("dp upper missing");

  property p_no_e2;
    @(posedge ref_clk) disable iff (rst)
      !(go & sAbsDp) |=> !e2WriteEn;
  endproperty
  a_no_e2: assert property (p_no_e2)
    else $error("stray e2 write");

  property p_sat32;
    @(posedge ref_clk) disable iff (rst)
      (go & lAbs32 & x2 == `AAXU_MIN32) |-> e1Result[31:0] == `AAXU_MAX32;
  endproperty
  a_sat32: assert property (p_sat32)
    else $error("abs32 saturate");

  property p_sat40;
    @(posedge ref_clk) disable iff (rst)
      (go & lAbs40 & src2Local == `AAXU_MIN40) |-> e1Result == `AAXU_MAX40;
  endproperty
  a_sat40: assert property (p_sat40)
    else $error("abs40 saturate");

  property p_int1;
    @(posedge ref_clk) disable iff (rst)
      (go & (isAdd | lAbs32 | lAbs40)) |-> e1WriteEn ##1 !e2WriteEn;
  endproperty
  a_int1: assert property (p_int1)
    else $error("int not in E1");

  property p_add;
    @(posedge ref_clk) disable iff (rst)
      (go & lAdd3232) |-> e1Result[31:0] == src1Local[31:0] + x2;
  endproperty
  a_add: assert property (p_add)
    else $error("add mismatch");

  property p_inf;
    @(posedge ref_clk) disable iff (rst)
      (go & sAbsSp & fpFlags.infiniteOut) |-> e1Result[31:0] == `AAXU_SP_INF;
  endproperty
  a_inf: assert property (p_inf)
    else $error("inf result");

  property p_snan;
    @(posedge ref_clk) disable iff (rst)
      (fpFlagsValid & fpFlags.illegalOperand) |->
        fpFlags.secondSrcNotNumber;
  endproperty
  a_snan: assert property (p_snan)
    else $error("snan flags");

  // Non-negative 32-bit operands pass through unchanged.
  property p_abs32_pos;
    @(posedge ref_clk) disable iff (rst)
      (go & lAbs32 & ~x2[31]) |-> e1Result == {8'h00, x2};
  endproperty
  a_abs32_pos: assert property (p_abs32_pos)
    else $error("abs32 positive");

  // Other negative 32-bit operands are simply negated.
  property p_abs32_neg;
    @(posedge ref_clk) disable iff (rst)
      (go & lAbs32 & x2[31] & (x2 != `AAXU_MIN32)) |->
        e1Result[31:0] == `AAXU_ZERO32 - x2;
  endproperty
  a_abs32_neg: assert property (p_abs32_neg)
    else $error("abs32 negate");

  // Other negative 40-bit operands are simply negated.
  property p_abs40_neg;
    @(posedge ref_clk) disable iff (rst)
      (go & lAbs40 & src2Local[39] & (src2Local != `AAXU_MIN40)) |->
        e1Result == 40'h00_0000_0000 - src2Local;
  endproperty
  a_abs40_neg: assert property (p_abs40_neg)
    else $error("abs40 negate");

  // With the cross bit the second addend is the opposite file's word.
  property p_cross;
    @(posedge ref_clk) disable iff (rst)
      (go & lAdd3232 & crossPath) |->
        e1Result[31:0] == src1Local[31:0] + src2Cross;
  endproperty
  a_cross: assert property (p_cross)
    else $error("cross operand");

  // The signed constant widens to 40 bits before the long add.
  property p_addc40;
    @(posedge ref_clk) disable iff (rst)
      (go & lAddC40) |->
        e1IsLong &&
        e1Result == src2Local + {{35{constField[4]}}, constField};
  endproperty
  a_addc40: assert property (p_addc40)
    else $error("long constant add");

  // A negative constant on the short form must borrow through bit 31.
  property p_addc32;
    @(posedge ref_clk) disable iff (rst)
      (go & lAddC32 & crossPath) |->
        e1Result[31:0] == src2Cross + {{27{constField[4]}}, constField};
  endproperty
  a_addc32: assert property (p_addc32)
    else $error("short constant add");

  // The address unit's constant is unsigned, so no sign is spread.
  property p_dadd;
    @(posedge ref_clk) disable iff (rst)
      (go & dAddU) |->
        e1Result[31:0] == src2Local[31:0] + {27'h0, constField};
  endproperty
  a_dadd: assert property (p_dadd)
    else $error("address unit add");

  // A denormal operand flushes to plus zero and raises both flags.
  property p_denorm;
    @(posedge ref_clk) disable iff (rst)
      (fpFlagsValid & fpFlags.roundingLoss) |->
        fpFlags.secondSrcSubnormal && e1Result == 40'h00_0000_0000;
  endproperty
  a_denorm: assert property (p_denorm)
    else $error("denormal result");

  // Any not-a-number operand leaves the canonical pattern in E1.
  property p_nan;
    @(posedge ref_clk) disable iff (rst)
      (fpFlagsValid & fpFlags.secondSrcNotNumber) |->
        e1Result[31:0] == (sAbsDp ? `AAXU_DP_NAN_LO : `AAXU_SP_NAN);
  endproperty
  a_nan: assert property (p_nan)
    else $error("nan result");

  // An infinite double writes plus infinity in its upper word in E2.
  property p_dp_inf;
    @(posedge ref_clk) disable iff (rst)
      (go & sAbsDp & fpFlags.infiniteOut) |=> e2Result == `AAXU_DP_INF_HI;
  endproperty
  a_dp_inf: assert property (p_dp_inf)
    else $error("dp inf upper word");

  // The single form never writes a long word or a negative value.
  property p_sp_unit;
    @(posedge ref_clk) disable iff (rst)
      (go & sAbsSp) |-> fpFlagsValid && !e1IsLong && !e1Result[31];
  endproperty
  a_sp_unit: assert property (p_sp_unit)
    else $error("sp magnitude form");
endmodule : aaxu_exec

// ===== verification/aaxu_rf_model.sv
// Register-file model that feeds operands to the execution datapath.
// Assumes the bench loads its registers between issues.
`timescale 1ns/100ps
module aaxu_rf_model (
  // Destination-side operands.
  output logic [39:0] src1Local,
  output logic [39:0] src2Local,
  output logic [31:0] src2HiLocal,
  // Opposite-side operands.
  output logic [31:0] src1Cross,
  output logic [31:0] src2Cross
);
  logic [39:0] fileA [0:2]; // Local file; entry 2 is the pair's upper word.
  logic [31:0] fileB [0:1]; // Opposite file, 32-bit words only.

  //////////////////////////////////////////////////////////////////////////
  // Reads are combinational, as register reads land within E1.
  assign src1Local   = fileA[0];
  assign src2Local   = fileA[1];
  assign src2HiLocal = fileA[2][31:0];
  assign src1Cross   = fileB[0];
  assign src2Cross   = fileB[1];
endmodule : aaxu_rf_model

// ===== verification/abs_add_exec_unit_tb.sv
// Self-checking bench for the magnitude and add execution datapath.
// Assumes combinational E1 outputs and a registered E2 word.
`timescale 1ns/100ps
`include "aaxu_defs.svh"
module abs_add_exec_unit_tb;
  logic ref_clk = 1'b0; // 100 MHz clock.
  logic rst = 1'b1;     // Active-high reset.
  logic issueValid = 1'b0, crossPath = 1'b0, predTrue = 1'b1;
  aaxu_pkg::aaxu_unit_e unitSel = aaxu_pkg::AAXU_UNIT_NONE;
  logic [6:0] opfield = 7'h00;
  logic [4:0] constField = 5'h00;
  logic [39:0] src1Local, src2Local, e1Result;
  logic [31:0] src2Cross, src2HiLocal, src1Cross, e2Result;
  logic e1WriteEn, e1IsLong, e2WriteEn, fpFlagsValid;
  aaxu_pkg::aaxu_flags_s fpFlags;
  int errorCnt = 0;  // Mismatches seen.
  int checks = 0;    // Comparisons made.

  always #5 ref_clk = ~ref_clk;

  aaxu_rf_model u_aaxu_rf_model (.src1Local(src1Local),
    .src2Local(src2Local), .src2HiLocal(src2HiLocal),
    .src1Cross(src1Cross), .src2Cross(src2Cross));
  aaxu_exec u_aaxu_exec (.ref_clk(ref_clk), .rst(rst),
    .issueValid(issueValid), .unitSel(unitSel), .opfield(opfield),
    .crossPath(crossPath), .predTrue(predTrue), .constField(constField),
    .src1Local(src1Local), .src2Local(src2Local), .src2Cross(src2Cross),
    .src2HiLocal(src2HiLocal), .src1Cross(src1Cross),
    .e1WriteEn(e1WriteEn), .e1Result(e1Result), .e1IsLong(e1IsLong),
    .e2WriteEn(e2WriteEn), .e2Result(e2Result), .fpFlags(fpFlags),
    .fpFlagsValid(fpFlagsValid));

  //////////////////////////////////////////////////////////////////////////
  // Compare helper; every comparison is counted.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Load operands; the upper word sits in the pair's entry 2.
  task automatic ld(input logic [39:0] a0, a1, input logic [31:0] a2, b0, b1);
    u_aaxu_rf_model.fileA[0] = a0;
    u_aaxu_rf_model.fileA[1] = a1;
    u_aaxu_rf_model.fileA[2] = {8'h00, a2};
    u_aaxu_rf_model.fileB[0] = b0;
    u_aaxu_rf_model.fileB[1] = b1;
  endtask : ld

  // One issue: E1 outputs are judged in the issue cycle, E2 one later.
  task automatic run(input aaxu_pkg::aaxu_unit_e u, input logic [6:0] op,
                     input logic x, p, input logic [4:0] c,
                     input logic [39:0] er, input logic el, dp, fv,
                     input logic [4:0] ef);
    @(negedge ref_clk);
    issueValid = 1'b1;
    unitSel = u;
    opfield = op;
    crossPath = x;
    predTrue = p;
    constField = c;
    #1;
    chk(e1WriteEn, p);
    chk(fpFlagsValid, fv & p);
    if (p) begin
      chk(e1Result, er);
      chk(e1IsLong, el);
    end
    if (fv & p) chk(fpFlags, ef);
    @(negedge ref_clk);
    issueValid = 1'b0;
    predTrue = 1'b1;
    #1;
    chk(e2WriteEn, dp & p);
  endtask : run

  //////////////////////////////////////////////////////////////////////////
  // Integer magnitude, including saturation of the most negative values.
  task automatic t_abs_int;
    ld(40'h0, 40'h00_FFFF_FFFB, 32'h0, 32'h0, 32'h8000_0000);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ABS32, 1'b0, 1'b1, 5'h00,
        40'h5, 1'b0, 1'b0, 1'b0, 5'h00);
    // The cross bit picks the opposite file's most negative word.
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ABS32, 1'b1, 1'b1, 5'h00,
        40'h00_7FFF_FFFF, 1'b0, 1'b0, 1'b0, 5'h00);
    ld(40'h0, `AAXU_MIN40, 32'h0, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ABS40, 1'b0, 1'b1, 5'h00,
        `AAXU_MAX40, 1'b1, 1'b0, 1'b0, 5'h00);
    ld(40'h0, 40'hFF_FFFF_FFF9, 32'h0, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ABS40, 1'b0, 1'b1, 5'h00,
        40'h7, 1'b1, 1'b0, 1'b0, 5'h00);
  endtask : t_abs_int

  // Add forms on all three units, with wrap, widening and constants.
  task automatic t_add;
    ld(40'h00_7FFF_FFFF, 40'h1, 32'h0, 32'h3, 32'h10);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ADD_32_32, 1'b1, 1'b1, 5'h00,
        40'h00_8000_000F, 1'b0, 1'b0, 1'b0, 5'h00);
    ld(40'h00_8000_0000, 40'h01_0000_0000, 32'h0, 32'hFFFF_FFFF,
       32'h8000_0000);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ADD_32_40W, 1'b1, 1'b1, 5'h00,
        40'hFF_0000_0000, 1'b1, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ADD_32L_40, 1'b1, 1'b1, 5'h00,
        40'h00_FFFF_FFFF, 1'b1, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ADD_C5_40, 1'b0, 1'b1, 5'h10,
        40'h00_FFFF_FFF0, 1'b1, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_L, `AAXU_L_ADD_C5_32, 1'b1, 1'b1, 5'h1F,
        40'h00_7FFF_FFFF, 1'b0, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_S, {1'b0, `AAXU_S_ADD_REG}, 1'b1, 1'b1, 5'h00,
        40'h0, 1'b0, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_S, {1'b0, `AAXU_S_ADD_C5}, 1'b0, 1'b1, 5'h1F,
        40'h00_FFFF_FFFF, 1'b0, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_D, {1'b0, `AAXU_D_ADD_REG}, 1'b0, 1'b1, 5'h00,
        40'h00_8000_0000, 1'b0, 1'b0, 1'b0, 5'h00);
    run(aaxu_pkg::AAXU_UNIT_D, {1'b0, `AAXU_D_ADD_U5}, 1'b0, 1'b1, 5'h1F,
        40'h1F, 1'b0, 1'b0, 1'b0, 5'h00);
  endtask : t_add

  // Single-precision magnitude: special operands and their flags.
  task automatic t_sp;
    logic [6:0] op;
    op = {1'b0, `AAXU_S_ABS_SP};
    ld(40'h0, 40'h7F80_0001, 32'h0, 32'h0, 32'hC020_0000);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b1, 5'h00,
        40'h7FFF_FFFF, 1'b0, 1'b0, 1'b1, 5'b11000);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b1, 1'b1, 5'h00,
        40'h4020_0000, 1'b0, 1'b0, 1'b1, 5'b00000);
    ld(40'h0, 40'h7FC0_0000, 32'h0, 32'h0, 32'h8000_0001);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b1, 5'h00,
        40'h7FFF_FFFF, 1'b0, 1'b0, 1'b1, 5'b01000);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b1, 1'b1, 5'h00,
        40'h0, 1'b0, 1'b0, 1'b1, 5'b00110);
    ld(40'h0, 40'hFF80_0000, 32'h0, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b1, 5'h00,
        40'h7F80_0000, 1'b0, 1'b0, 1'b1, 5'b00001);
  endtask : t_sp

  // Double precision: low word in E1, high word in E2, also for the
  // special operands; then a false predicate must leave no trace.
  task automatic t_dp;
    logic [6:0] op;
    op = {1'b0, `AAXU_S_ABS_DP};
    ld(40'h0, 40'h1234_5678, 32'hC004_0000, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b1, 5'h00,
        40'h1234_5678, 1'b0, 1'b1, 1'b1, 5'b00000);
    chk(e2Result, 32'h4004_0000);
    // Signalling double: canonical low word now, upper word next.
    ld(40'h0, 40'h0, 32'h7FF0_0001, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b1, 5'h00,
        40'h00_FFFF_FFFF, 1'b0, 1'b1, 1'b1, 5'b11000);
    chk(e2Result, 32'h7FFF_FFFF);
    // Minus infinity turns positive across both words.
    ld(40'h0, 40'h0, 32'hFFF0_0000, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b1, 5'h00,
        40'h0, 1'b0, 1'b1, 1'b1, 5'b00001);
    chk(e2Result, 32'h7FF0_0000);
    ld(40'h0, 40'h0, 32'h7FF0_0001, 32'h0, 32'h0);
    run(aaxu_pkg::AAXU_UNIT_S, op, 1'b0, 1'b0, 5'h00,
        40'h0, 1'b0, 1'b1, 1'b1, 5'b11000);
  endtask : t_dp

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic testDone;
    $display("checks=%0d errorCnt=%0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : testDone

  initial begin
    ld(40'h0, 40'h0, 32'h0, 32'h0, 32'h0);
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_abs_int();
    t_add();
    t_sp();
    t_dp();
    testDone();
  end
endmodule : abs_add_exec_unit_tb
